// *** verilog/port3_cfg.svh ***
// port3_cfg.svh: register offsets, field positions and reset values for the two-pin port block
// assumes inclusion by bare name from design files under verilog/
`ifndef PORT3_CFG_SVH
`define PORT3_CFG_SVH

// register byte addresses
`define P3_ADDR_LATCH       12'h000
`define P3_ADDR_MODE1       12'h004
`define P3_ADDR_MODE2       12'h008
`define P3_ADDR_TRIM        12'h00c
`define P3_ADDR_STATUS      12'h010
`define P3_ADDR_CLKSRC      12'h014
// trim register fields
`define P3_TRIM_CLK_OUT_EN_BIT 6
`define P3_TRIM_RSV_BIT     7
`define P3_TRIM_RESET       8'h00
// mode registers reset: both pins input only (mode1=1, mode2=0)
`define P3_MODE1_RESET      2'h3
`define P3_MODE2_RESET      2'h0
`define P3_LATCH_RESET      2'h3
// clock source register fields (from flash config, read only)
`define P3_CLKSRC_CPU_LSB   0
`define P3_CLKSRC_RTC_BIT   2
// status register fixed bits
`define P3_STATUS_FIXED1    7
// axi response codes
`define AXI_RESP_OKAY       2'h0
`define AXI_RESP_SLVERR     2'h2

`endif

// *** verilog/port3_pkg.sv ***
// port3_pkg.sv: types for the two-pin port block
// assumes the cfg header for numeric constants
package port3_pkg;
    typedef enum logic [1:0] {
        cpu_clk_rc,
        cpu_clk_wdt,
        cpu_clk_ext,
        cpu_clk_xtal
    } cpu_clk_src_t;

    typedef enum logic [1:0] {
        pm_quasi,
        pm_push_pull,
        pm_input_only,
        pm_open_drain
    } pin_mode_t;

    typedef struct packed {
        logic o;
        logic oe_n;
    } pin_drive_t;
endpackage : port3_pkg

// *** verilog/port3_pin_cell.sv ***
// port3_pin_cell.sv: one port bit, mode-driven output stage
// assumes a single clock domain and synchronous pin inputs
`timescale 1ns/1ps
`default_nettype none
module port3_pin_cell (
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire port3_pkg::pin_mode_t mode,
    input  wire logic                latch,
    input  wire logic                pin_in,
    output var  port3_pkg::pin_drive_t drive,
    output logic                     pullup_en
);
    logic pin_q_reg;

    // quasi mode never drives high: it sinks low on latch 0, pull-up on while latch is 1 or the registered pin is low
    always_ff @(posedge clk) begin
        if (rst) begin
            pin_q_reg <= 1'b0;
        end else begin
            pin_q_reg <= pin_in;
        end
    end

    always_comb begin
        drive.o    = latch;
        drive.oe_n = 1'b1;
        pullup_en  = 1'b0;
        case (mode)
            port3_pkg::pm_quasi: begin
                drive.o    = 1'b0;
                drive.oe_n = latch;
                pullup_en  = latch | ~pin_q_reg;
            end
            port3_pkg::pm_push_pull: begin
                drive.oe_n = 1'b0;
            end
            port3_pkg::pm_open_drain: begin
                drive.o    = 1'b0;
                drive.oe_n = latch;
            end
            default: begin
                drive.oe_n = 1'b1;
            end
        endcase
    end
endmodule : port3_pin_cell
`default_nettype wire

// *** verilog/port3_clk_div.sv ***
// port3_clk_div.sv: cpu clock divided by two
// assumes clk is the cpu clock
`timescale 1ns/1ps
`default_nettype none
module port3_clk_div (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic enable,
    output logic      div_out
);
    // held low when off so the pin never glitches on enable
    always_ff @(posedge clk) begin
        if (rst || !enable) begin
            div_out <= 1'b0;
        end else begin
            div_out <= ~div_out;
        end
    end
endmodule : port3_clk_div
`default_nettype wire

// *** verilog/port3_clock_pin_mux.sv ***
// Overview of operation
// - the port is two bits wide, output type chosen by software
// - under reset both pins are input only, pull-up off
// - each pin has its own mode, independent of the other
// - trim bit six sends cpu clock divided by two to pin zero unless a crystal option is selected
// - crystal option makes pin zero the oscillator amplifier output
// - flash option routes pin one into the oscillator circuit
// - pin one is a port bit only for rc or watchdog clock, no crystal rtc
// - reserved bits are written zero and read back as zero here
// - fixed bits always read their fixed value
//
// port3_clock_pin_mux.sv: top of the two-pin port with oscillator and clock out sharing
// assumes an axi4-lite master on clk; flash clock selection is static after reset
`timescale 1ns/1ps
`default_nettype none
`include "port3_cfg.svh"
module port3_clock_pin_mux (
    input  wire logic                    clk,
    input  wire logic                    rst,
    input  wire logic [11:0]             s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [11:0]             s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    input  wire port3_pkg::cpu_clk_src_t cpu_clk_src,
    input  wire logic                    xtal_rtc_sel,
    input  wire logic                    port3_bit_zero_in,
    output logic                         port3_bit_zero_out,
    output logic                         port3_bit_zero_oe_n,
    output logic                         port3_bit_zero_pullup,
    input  wire logic                    port3_bit_one_in,
    output logic                         port3_bit_one_out,
    output logic                         port3_bit_one_oe_n,
    output logic                         port3_bit_one_pullup,
    output logic                         osc_input_pin,
    output logic                         osc_amp_output_sel,
    output logic                         osc_input_sel
);
    logic [1:0] latch_reg;
    logic [1:0] mode1_reg;
    logic [1:0] mode2_reg;
    logic       clock_output_enable_reg;
    logic [1:0] pin_in_reg;
    logic       crystal_sel;
    logic       pin1_is_port;
    logic       divided_clock_output;
    port3_pkg::pin_drive_t drive [2];
    logic [1:0] pull_on;
    port3_pkg::pin_mode_t  mode [2];
    logic [1:0] pin_in;

    assign pin_in = {port3_bit_one_in, port3_bit_zero_in};

    // flash clock option decides the pin roles
    assign crystal_sel  = (cpu_clk_src == port3_pkg::cpu_clk_xtal) || xtal_rtc_sel;
    assign pin1_is_port = ((cpu_clk_src == port3_pkg::cpu_clk_rc) ||
                           (cpu_clk_src == port3_pkg::cpu_clk_wdt)) && !xtal_rtc_sel;

    // per-pin stages, each with its own mode pair
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_pin
            // mode1 low swaps quasi and push-pull codes; mode1 high maps straight through
            assign mode[gi] = port3_pkg::pin_mode_t'({mode1_reg[gi], mode2_reg[gi] ^ ~mode1_reg[gi]});
            port3_pin_cell u_cell (
                .clk       (clk),
                .rst       (rst),
                .mode      (mode[gi]),
                .latch     (latch_reg[gi]),
                .pin_in    (pin_in[gi]),
                .drive     (drive[gi]),
                .pullup_en (pull_on[gi])
            );
        end
    endgenerate

    port3_clk_div u_div (
        .clk     (clk),
        .rst     (rst),
        .enable  (clock_output_enable_reg && !crystal_sel),
        .div_out (divided_clock_output)
    );

    // pin outputs all registered; reset forces input only, pull-up off
    always_ff @(posedge clk) begin
        if (rst) begin
            port3_bit_zero_out    <= 1'b0;
            port3_bit_zero_oe_n   <= 1'b1;
            port3_bit_zero_pullup <= 1'b0;
            port3_bit_one_out     <= 1'b0;
            port3_bit_one_oe_n    <= 1'b1;
            port3_bit_one_pullup  <= 1'b0;
        end else begin
            if (crystal_sel) begin
                // amplifier owns the pin; port stage released
                port3_bit_zero_out    <= 1'b0;
                port3_bit_zero_oe_n   <= 1'b1;
                port3_bit_zero_pullup <= 1'b0;
            end else if (clock_output_enable_reg) begin
                port3_bit_zero_out    <= ~divided_clock_output;
                port3_bit_zero_oe_n   <= 1'b0;
                port3_bit_zero_pullup <= 1'b0;
            end else begin
                port3_bit_zero_out    <= drive[0].o;
                port3_bit_zero_oe_n   <= drive[0].oe_n;
                port3_bit_zero_pullup <= pull_on[0];
            end
            if (pin1_is_port) begin
                port3_bit_one_out    <= drive[1].o;
                port3_bit_one_oe_n   <= drive[1].oe_n;
                port3_bit_one_pullup <= pull_on[1];
            end else begin
                port3_bit_one_out    <= 1'b0;
                port3_bit_one_oe_n   <= 1'b1;
                port3_bit_one_pullup <= 1'b0;
            end
        end
    end

    // oscillator routing
    always_ff @(posedge clk) begin
        if (rst) begin
            osc_input_pin      <= 1'b0;
            osc_amp_output_sel <= 1'b0;
            osc_input_sel      <= 1'b0;
            pin_in_reg         <= 2'h0;
        end else begin
            osc_amp_output_sel <= crystal_sel;
            osc_input_sel      <= !pin1_is_port;
            osc_input_pin      <= pin1_is_port ? 1'b0 : port3_bit_one_in;
            pin_in_reg         <= pin_in;
        end
    end

    // axi4-lite write path: address and data taken in either order
    logic        aw_held_reg;
    logic        w_held_reg;
    logic [11:0] awaddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0]  wstrb_reg;
    logic        wr_go;
    logic        wr_hit;

    assign wr_go  = aw_held_reg && w_held_reg && !s_axi_bvalid;
    assign wr_hit = (awaddr_reg == `P3_ADDR_LATCH) || (awaddr_reg == `P3_ADDR_MODE1) ||
                    (awaddr_reg == `P3_ADDR_MODE2) || (awaddr_reg == `P3_ADDR_TRIM);

    always_ff @(posedge clk) begin
        if (rst) begin
            aw_held_reg   <= 1'b0;
            w_held_reg    <= 1'b0;
            awaddr_reg    <= 12'h000;
            wdata_reg     <= 32'h00000000;
            wstrb_reg     <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `AXI_RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_held_reg && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_held_reg && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb_reg  <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // register file; only the low byte lane carries fields
    always_ff @(posedge clk) begin
        if (rst) begin
            latch_reg               <= `P3_LATCH_RESET;
            mode1_reg               <= `P3_MODE1_RESET;
            mode2_reg               <= `P3_MODE2_RESET;
            clock_output_enable_reg <= 1'b0;
        end else if (wr_go && wstrb_reg[0]) begin
            case (awaddr_reg)
                `P3_ADDR_LATCH: latch_reg <= wdata_reg[1:0];
                `P3_ADDR_MODE1: mode1_reg <= wdata_reg[1:0];
                `P3_ADDR_MODE2: mode2_reg <= wdata_reg[1:0];
                `P3_ADDR_TRIM: clock_output_enable_reg <= wdata_reg[`P3_TRIM_CLK_OUT_EN_BIT];
                default: begin
                end
            endcase
        end
    end

    // axi4-lite read path
    logic [31:0] rd_word;
    logic        rd_hit;

    always_comb begin
        rd_word = 32'h00000000;
        rd_hit  = 1'b1;
        case (s_axi_araddr)
            `P3_ADDR_LATCH: rd_word[1:0] = latch_reg;
            `P3_ADDR_MODE1: rd_word[1:0] = mode1_reg;
            `P3_ADDR_MODE2: rd_word[1:0] = mode2_reg;
            `P3_ADDR_TRIM: rd_word[`P3_TRIM_CLK_OUT_EN_BIT] = clock_output_enable_reg;
            `P3_ADDR_STATUS: begin
                rd_word[1:0]              = pin_in_reg;
                rd_word[`P3_STATUS_FIXED1] = 1'b1;
            end
            `P3_ADDR_CLKSRC: begin
                rd_word[`P3_CLKSRC_CPU_LSB +: 2] = cpu_clk_src;
                rd_word[`P3_CLKSRC_RTC_BIT]      = xtal_rtc_sel;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `AXI_RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= rd_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // checks
    property p_reset_input_only;
        @(posedge clk) rst |=> (port3_bit_zero_oe_n && port3_bit_one_oe_n &&
                               !port3_bit_zero_pullup && !port3_bit_one_pullup);
    endproperty
    a_reset_input_only: assert property (p_reset_input_only) else $error("pin not input only after reset");

    property p_divided_clock_output_toggles;
        @(posedge clk) disable iff (rst)
        (clock_output_enable_reg && !crystal_sel)[*3] |=> (port3_bit_zero_out != $past(port3_bit_zero_out));
    endproperty
    a_divided_clock_output_toggles: assert property (p_divided_clock_output_toggles) else $error("clock out not toggling");

    property p_divided_clock_output_drives;
        @(posedge clk) disable iff (rst)
        (clock_output_enable_reg && !crystal_sel) |=> !port3_bit_zero_oe_n;
    endproperty
    a_divided_clock_output_drives: assert property (p_divided_clock_output_drives) else $error("clock out not driven");

    property p_xtal_releases_pin0;
        @(posedge clk) disable iff (rst) crystal_sel |=> port3_bit_zero_oe_n && osc_amp_output_sel;
    endproperty
    a_xtal_releases_pin0: assert property (p_xtal_releases_pin0) else $error("pin zero not given to oscillator");

    property p_pin1_osc;
        @(posedge clk) disable iff (rst) !pin1_is_port |=> port3_bit_one_oe_n && osc_input_sel;
    endproperty
    a_pin1_osc: assert property (p_pin1_osc) else $error("pin one not routed to oscillator");

    property p_pin1_port;
        @(posedge clk) disable iff (rst)
        (pin1_is_port && mode1_reg[1] == 1'b0 && mode2_reg[1] == 1'b0) |=> !port3_bit_one_oe_n;
    endproperty
    a_pin1_port: assert property (p_pin1_port) else $error("pin one not acting as push-pull port bit");

    property p_pin_independent;
        @(posedge clk) disable iff (rst)
        (pin1_is_port && $stable(mode1_reg[1]) && $stable(mode2_reg[1]) && $stable(latch_reg[1]) &&
         mode1_reg[1] && !mode2_reg[1]) |=> port3_bit_one_oe_n;
    endproperty
    a_pin_independent: assert property (p_pin_independent) else $error("pin one mode disturbed");

    property p_unmapped_read;
        @(posedge clk) disable iff (rst)
        (s_axi_arvalid && s_axi_arready && !rd_hit) |=> s_axi_rvalid && s_axi_rresp == `AXI_RESP_SLVERR;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not refused");

    property p_fixed_bit;
        @(posedge clk) disable iff (rst)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == `P3_ADDR_STATUS) |=>
            s_axi_rdata[`P3_STATUS_FIXED1] && s_axi_rdata[31:8] == 24'h000000;
    endproperty
    a_fixed_bit: assert property (p_fixed_bit) else $error("fixed or reserved bit wrong");

    c_divided_clock_output:  cover property (@(posedge clk) disable iff (rst) clock_output_enable_reg && !crystal_sel);
    c_crystal: cover property (@(posedge clk) disable iff (rst) crystal_sel);
    c_write:   cover property (@(posedge clk) disable iff (rst) s_axi_bvalid && s_axi_bready);
    c_read:    cover property (@(posedge clk) disable iff (rst) s_axi_rvalid && s_axi_rready);
endmodule : port3_clock_pin_mux
`default_nettype wire

// *** tb/port3_board_model.sv ***
// port3_board_model.sv: board around the two port pins, resolves each pin level
// assumes one bench clock; a pin the device drives wins over the board driver
`timescale 1ns/1ps
`default_nettype none
module port3_board_model (
    input  wire logic       clk,
    input  wire logic [1:0] oe_n,
    input  wire logic [1:0] dev_out,
    input  wire logic [1:0] pull_on,
    input  wire logic [1:0] ext_en,
    input  wire logic [1:0] ext_val,
    output logic      [1:0] pin
);
    logic [1:0] float_reg = 2'h1;
    // a line nobody drives keeps changing, so no lucky settle to 0 or 1
    always @(posedge clk) begin
        float_reg <= ~float_reg;
    end
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            if (!oe_n[i]) begin
                pin[i] = dev_out[i];
            end else if (ext_en[i]) begin
                pin[i] = ext_val[i];
            end else if (pull_on[i]) begin
                pin[i] = 1'b1;
            end else begin
                pin[i] = float_reg[i];
            end
        end
    end
endmodule : port3_board_model
`default_nettype wire

// *** tb/port3_clock_pin_mux_bench.sv ***
// port3_clock_pin_mux_bench.sv: self-checking bench for the two-pin port block
// assumes the design files and the board model are compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "port3_cfg.svh"
module port3_clock_pin_mux_bench;
    typedef struct packed {
        port3_pkg::cpu_clk_src_t src;
        logic                    rtc;
        logic                    en;
        logic [4:0]              exp; // amp sel, input sel, oe_n zero, oe_n one, osc input
    } row_t;
    // rtc rows never enable clock out: software keeps off it there
    row_t rows [6] = '{'{port3_pkg::cpu_clk_rc, 1'b0, 1'b0, 5'b00100},
                       '{port3_pkg::cpu_clk_wdt, 1'b0, 1'b1, 5'b00000},
                       '{port3_pkg::cpu_clk_ext, 1'b0, 1'b1, 5'b01011},
                       '{port3_pkg::cpu_clk_xtal, 1'b0, 1'b0, 5'b11111},
                       '{port3_pkg::cpu_clk_rc, 1'b1, 1'b0, 5'b11111},
                       '{port3_pkg::cpu_clk_wdt, 1'b1, 1'b0, 5'b11111}};
    logic [11:0] rst_addr [6] = '{`P3_ADDR_LATCH, `P3_ADDR_MODE1, `P3_ADDR_MODE2,
                                  `P3_ADDR_TRIM, `P3_ADDR_STATUS, `P3_ADDR_CLKSRC};
    // status: fixed bit seven, board holds pin one high and pin zero low
    logic [31:0] rst_val [6] = '{{30'h0, `P3_LATCH_RESET}, {30'h0, `P3_MODE1_RESET},
                                 {30'h0, `P3_MODE2_RESET}, {24'h0, `P3_TRIM_RESET}, 32'h82, 32'h0};
    logic                    clk = 1'b0, rst = 1'b1;
    logic [11:0]             awaddr = 12'h0, araddr = 12'h0;
    logic [31:0]             wdata = 32'h0, rdata;
    logic [3:0]              wstrb = 4'h0;
    logic                    awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic                    awready, wready, bvalid, arready, rvalid;
    logic [1:0]              bresp, rresp, pin;
    port3_pkg::cpu_clk_src_t cpu_clk_src = port3_pkg::cpu_clk_rc;
    logic                    xtal_rtc_sel = 1'b0;
    logic                    out0, oe0, pu0, out1, oe1, pu1, osc_in, amp_sel, in_sel;
    logic [31:0]             rd;
    logic [1:0]              rs;
    logic                    prev;
    int                      n_errors = 0, n_tests = 0;

    always #20 clk = ~clk;

    port3_clock_pin_mux uut (
        .clk(clk), .rst(rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .cpu_clk_src(cpu_clk_src), .xtal_rtc_sel(xtal_rtc_sel),
        .port3_bit_zero_in(pin[0]), .port3_bit_zero_out(out0), .port3_bit_zero_oe_n(oe0),
        .port3_bit_zero_pullup(pu0), .port3_bit_one_in(pin[1]), .port3_bit_one_out(out1),
        .port3_bit_one_oe_n(oe1), .port3_bit_one_pullup(pu1), .osc_input_pin(osc_in),
        .osc_amp_output_sel(amp_sel), .osc_input_sel(in_sel)
    );
    // board holds pin one high, pin zero low whenever the device lets go
    port3_board_model board (
        .clk(clk), .oe_n({oe1, oe0}), .dev_out({out1, out0}), .pull_on({pu1, pu0}),
        .ext_en(2'h3), .ext_val(2'h2), .pin(pin)
    );

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] expd);
        n_tests++;
        if (seen !== expd) begin
            n_errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, expd);
        end
    endtask : check

    task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                             output logic [1:0] resp);
        logic a_hit, w_hit, fin;
        fin = 1'b0;
        resp = 2'h3;
        @(posedge clk);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (int k = 0; k < 40 && !fin; k++) begin
            @(negedge clk);
            a_hit = awvalid && awready;
            w_hit = wvalid && wready;
            fin   = bvalid;
            resp  = bresp;
            @(posedge clk);
            if (a_hit) awvalid <= 1'b0;
            if (w_hit) wvalid <= 1'b0;
            if (fin) bready <= 1'b0;
        end
        if (!fin) begin
            n_errors++;
            give_verdict();
        end
    endtask : axi_write

    task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] resp);
        logic a_hit, fin;
        fin = 1'b0;
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (int k = 0; k < 40 && !fin; k++) begin
            @(negedge clk);
            a_hit = arvalid && arready;
            fin   = rvalid;
            d     = rdata;
            resp  = rresp;
            @(posedge clk);
            if (a_hit) arvalid <= 1'b0;
            if (fin) rready <= 1'b0;
        end
        if (!fin) begin
            n_errors++;
            give_verdict();
        end
    endtask : axi_read

    task automatic do_reset(input port3_pkg::cpu_clk_src_t src, input logic rtc);
        @(posedge clk);
        rst          <= 1'b1;
        cpu_clk_src  <= src;
        xtal_rtc_sel <= rtc;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
    endtask : do_reset

    initial begin
        // pin zero input only, pin one push-pull driving a one
        foreach (rows[i]) begin
            do_reset(rows[i].src, rows[i].rtc);
            axi_write(`P3_ADDR_MODE1, 32'h1, 4'hf, rs);
            axi_write(`P3_ADDR_MODE2, 32'h0, 4'hf, rs);
            axi_write(`P3_ADDR_LATCH, 32'h2, 4'hf, rs);
            axi_write(`P3_ADDR_TRIM, {25'h0, rows[i].en, 6'h0}, 4'hf, rs);
            axi_read(`P3_ADDR_CLKSRC, rd, rs);
            check(rd, {29'h0, rows[i].rtc, rows[i].src});
            repeat (2) @(posedge clk);
            @(negedge clk);
            check({amp_sel, in_sel, oe0, oe1, osc_in}, rows[i].exp);
            if (!rows[i].exp[3]) check(out1, 1'b1);
        end
        // clock out toggles each cycle whatever the latch holds
        do_reset(port3_pkg::cpu_clk_rc, 1'b0);
        axi_write(`P3_ADDR_TRIM, 32'h40, 4'hf, rs);
        for (int j = 0; j < 2; j++) begin
            axi_write(`P3_ADDR_LATCH, {31'h0, j[0]}, 4'hf, rs);
            repeat (2) @(posedge clk);
            @(negedge clk);
            prev = out0;
            repeat (6) begin
                @(negedge clk);
                check(out0 ^ prev, 1'b1);
                check(oe0, 1'b0);
                prev = out0;
            end
        end
        // no byte strobe: ignored but answered okay
        axi_write(`P3_ADDR_TRIM, 32'h0, 4'h0, rs);
        check(rs, `AXI_RESP_OKAY);
        axi_read(`P3_ADDR_TRIM, rd, rs);
        check(rd, 32'h40);
        // undefined place answers an error, stores nothing
        axi_write(12'h018, 32'hff, 4'hf, rs);
        check(rs, `AXI_RESP_SLVERR);
        axi_read(12'h018, rd, rs);
        check(rs, `AXI_RESP_SLVERR);
        check(rd, 32'h0);
        // second reset while clock out runs
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        @(negedge clk);
        check({oe1, oe0, pu1, pu0, amp_sel, in_sel, out1, out0}, 8'hc0);
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        foreach (rst_addr[i]) begin
            axi_read(rst_addr[i], rd, rs);
            check(rd, rst_val[i]);
        end
        give_verdict();
    end
endmodule : port3_clock_pin_mux_bench
`default_nettype wire
